// ---- core_interrupt_control_reg.sv ----
`timescale 1ns/100ps
module core_interrupt_control_reg
   import core_irq_pkg::*;
#(
   parameter int unsigned ADDR_W = 12
) (
   input  wire logic        hclk,             // system clock
   input  wire logic        hresetn,          // async reset, low
   input  wire logic        hsel,             // slave select
   input  wire logic [31:0] haddr,            // byte address
   input  wire logic [1:0]  htrans,           // transfer type
   input  wire logic        hwrite,           // write when high
   input  wire logic [2:0]  hsize,            // transfer size
   input  wire logic        hready,           // bus ready in
   input  wire logic [31:0] hwdata,           // write data
   output logic [31:0]      hrdata,           // read data
   output logic             hreadyout,        // slave ready
   output logic             hresp,            // always okay
   input  wire logic        timer0_overflow,  // overflow pulse
   input  wire logic        portb_mismatch,   // change level
   input  wire logic        external_edge_pin,// edge pin level
   input  wire logic        edge_rising_sel,  // edge polarity
   input  wire logic        periph_irq_pend,  // group pending
   output logic             core_irq_req,     // to core
   output logic             irq               // event summary
);

   // decode needs every bank alias bit, bus gives 32
   if (ADDR_W < ADDR_W_MIN || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W out of range");
   end

   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [11:0] r);
      return a == ADDR_W'(r);
   endfunction

   function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
      return addr_is(a, ADDR_CTRL_BANK0) | addr_is(a, ADDR_CTRL_BANK1) |
             addr_is(a, ADDR_CTRL_BANK2) | addr_is(a, ADDR_CTRL_BANK3);
   endfunction

   logic [ADDR_W-1:0] addr_q;
   logic              wr_pend_q;
   logic              rd_pend_q;
   logic [31:0]       hrdata_q;
   logic [4:0]        ctrl_en_q;
   logic [2:0]        evt_en_q;
   logic [2:0]        flags;
   logic [2:0]        evt_stat;
   logic [2:0]        src_evt;
   logic              edge_pulse;
   logic              addr_phase;
   logic              wr_ctrl;
   logic              wr_clr;
   logic              wr_evt_en;
   logic              rd_ctrl;
   logic              rd_stat;
   logic              rd_evt_en;
   logic [7:0]        ctrl_word;
   logic [31:0]       rd_word;
   logic              global_irq_enable;
   logic              peripheral_irq_enable;

   // bus handshake
   assign addr_phase = hsel & htrans[1] & hready;
   assign hreadyout  = ~rd_pend_q;
   assign hresp      = HRESP_OKAY;
   assign hrdata     = hrdata_q;

   assign wr_ctrl   = wr_pend_q & is_ctrl(addr_q);
   assign rd_ctrl   = is_ctrl(addr_q);
   assign wr_clr    = wr_pend_q & addr_is(addr_q, ADDR_EVT_CLEAR);
   assign wr_evt_en = wr_pend_q & addr_is(addr_q, ADDR_EVT_ENABLE);
   assign rd_stat   = addr_is(addr_q, ADDR_EVT_STATUS);
   assign rd_evt_en = addr_is(addr_q, ADDR_EVT_ENABLE);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q    <= '0;
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
      end else begin
         wr_pend_q <= addr_phase & hwrite & (hsize == HSIZE_WORD);
         rd_pend_q <= addr_phase & ~hwrite;
         if (addr_phase) begin
            addr_q <= haddr[ADDR_W-1:0];
         end
      end
   end

   // read data loaded during the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0;
      end else if (rd_pend_q) begin
         hrdata_q <= rd_word;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_en_q <= CTRL_RESET[GLOBAL_EN_BIT:PORTB_EN_BIT];
         evt_en_q  <= EVT_EN_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_en_q <= hwdata[GLOBAL_EN_BIT:PORTB_EN_BIT];
         end
         if (wr_evt_en) begin
            evt_en_q <= hwdata[NUM_SRC-1:0];
         end
      end
   end

   pin_edge_detect u_edge (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .pin        (external_edge_pin),
      .rising_sel (edge_rising_sel),
      .edge_pulse (edge_pulse)
   );

   assign src_evt[TIMER0_FLG_BIT] = timer0_overflow;
   assign src_evt[EDGE_FLG_BIT]   = edge_pulse;
   assign src_evt[PORTB_FLG_BIT]  = portb_mismatch;

   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      sticky_flag_cell u_flag (
         .hclk    (hclk),
         .hresetn (hresetn),
         .set     (src_evt[i]),
         .wr_en   (wr_ctrl),
         .wr_val  (hwdata[i]),
         .q       (flags[i])
      );
      // sticky event status, write one clears
      sticky_flag_cell u_stat (
         .hclk    (hclk),
         .hresetn (hresetn),
         .set     (src_evt[i]),
         .wr_en   (wr_clr & hwdata[i]),
         .wr_val  (1'b0),
         .q       (evt_stat[i])
      );
   end

   assign ctrl_word = {ctrl_en_q, flags};
   assign global_irq_enable     = ctrl_en_q[GLOBAL_EN_BIT - PORTB_EN_BIT];
   assign peripheral_irq_enable = ctrl_en_q[PERIPH_EN_BIT - PORTB_EN_BIT];

   assign rd_word = rd_ctrl   ? {24'h0, ctrl_word} :
                    rd_stat   ? {29'h0, evt_stat}  :
                    rd_evt_en ? {29'h0, evt_en_q}  : 32'h0;

   assign core_irq_req = global_irq_enable & (
      (ctrl_word[TIMER0_EN_BIT] & ctrl_word[TIMER0_FLG_BIT]) |
      (ctrl_word[EDGE_EN_BIT]   & ctrl_word[EDGE_FLG_BIT])   |
      (ctrl_word[PORTB_EN_BIT]  & ctrl_word[PORTB_FLG_BIT])  |
      (peripheral_irq_enable & periph_irq_pend));

   assign irq = |(evt_stat & evt_en_q);

endmodule

// ---- core_irq_checker.sv ----
`timescale 1ns/100ps
module core_irq_checker
   import core_irq_pkg::*;
#(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic        hclk,            // clock
   input wire logic        hresetn,         // reset
   input wire logic        hsel,            // select
   input wire logic [31:0] haddr,           // address
   input wire logic [1:0]  htrans,          // type
   input wire logic        hwrite,          // write
   input wire logic [2:0]  hsize,           // size
   input wire logic        hready,          // ready in
   input wire logic [31:0] hwdata,          // wdata
   input wire logic [31:0] hrdata,          // rdata
   input wire logic        hreadyout,       // ready out
   input wire logic        hresp,           // resp
   input wire logic        periph_irq_pend, // pending
   input wire logic        core_irq_req     // request
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire       acc = hsel & htrans[1] & hready;
   wire       rd  = acc & !hwrite;
   wire       unm = rd & (haddr[11:0] == 12'h030);
   wire [7:0] wd  = hwdata[7:0];
   wire       ctl = acc & hwrite & (hsize == HSIZE_WORD) & (haddr[11:0] inside
      {ADDR_CTRL_BANK0, ADDR_CTRL_BANK1, ADDR_CTRL_BANK2, ADDR_CTRL_BANK3});
   okay_resp_a: assert property (hresp == HRESP_OKAY)
      else $error("response not okay");
   read_wait_a: assert property (rd |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_nowait_a: assert property (acc & hwrite |=> hreadyout)
      else $error("write stalled");
   unmapped_zero_a: assert property (unm |=> ##1 hrdata == 32'h0)
      else $error("unmapped read not zero");
   enabled_req_a: assert property ((ctl ##1 wd == 8'ha4) |=> core_irq_req)
      else $error("request missing");
   global_off_a: assert property ((ctl ##1 !wd[7]) |=> !core_irq_req)
      else $error("request without global enable");
   periph_on_a: assert property ((ctl ##1 wd == 8'hc0) |=> core_irq_req == periph_irq_pend)
      else $error("peripheral request wrong");
   periph_off_a: assert property ((ctl ##1 wd == 8'h80) |=> !core_irq_req)
      else $error("peripheral not masked");
   cover property ((ctl ##1 wd == 8'hc0) ##1 core_irq_req);
   cover property (rd ##2 hreadyout);
   cover property (unm);
endmodule
bind core_interrupt_control_reg core_irq_checker #(.ADDR_W(ADDR_W)) chk_u (.*);

// ---- core_irq_pkg.sv ----
package core_irq_pkg;

   // register indices; byte address is four times the index
   localparam logic [9:0]  IDX_CTRL_BANK0 = 10'h00b;
   localparam logic [9:0]  IDX_CTRL_BANK1 = 10'h08b;
   localparam logic [9:0]  IDX_CTRL_BANK2 = 10'h10b;
   localparam logic [9:0]  IDX_CTRL_BANK3 = 10'h18b;
   localparam logic [9:0]  IDX_EVT_STATUS = 10'h1c0;
   localparam logic [9:0]  IDX_EVT_CLEAR  = 10'h1c1;
   localparam logic [9:0]  IDX_EVT_ENABLE = 10'h1c2;

   localparam logic [11:0] ADDR_CTRL_BANK0 = {IDX_CTRL_BANK0, 2'h0};
   localparam logic [11:0] ADDR_CTRL_BANK1 = {IDX_CTRL_BANK1, 2'h0};
   localparam logic [11:0] ADDR_CTRL_BANK2 = {IDX_CTRL_BANK2, 2'h0};
   localparam logic [11:0] ADDR_CTRL_BANK3 = {IDX_CTRL_BANK3, 2'h0};
   localparam logic [11:0] ADDR_EVT_STATUS = {IDX_EVT_STATUS, 2'h0};
   localparam logic [11:0] ADDR_EVT_CLEAR  = {IDX_EVT_CLEAR, 2'h0};
   localparam logic [11:0] ADDR_EVT_ENABLE = {IDX_EVT_ENABLE, 2'h0};

   // interrupt_control field positions
   localparam int unsigned GLOBAL_EN_BIT  = 7;
   localparam int unsigned PERIPH_EN_BIT  = 6;
   localparam int unsigned TIMER0_EN_BIT  = 5;
   localparam int unsigned EDGE_EN_BIT    = 4;
   localparam int unsigned PORTB_EN_BIT   = 3;
   localparam int unsigned TIMER0_FLG_BIT = 2;
   localparam int unsigned EDGE_FLG_BIT   = 1;
   localparam int unsigned PORTB_FLG_BIT  = 0;
   localparam int unsigned NUM_SRC        = 3;

   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam logic [2:0]  EVT_EN_RESET   = 3'h0;

   localparam logic [2:0]  HSIZE_WORD     = 3'h2;
   localparam logic        HRESP_OKAY     = 1'h0;
   localparam int unsigned ADDR_W_MIN     = 12;

endpackage

// ---- event_source_model.sv ----
`timescale 1ns/100ps
module event_source_model (
   input  wire logic       hclk,     // clock
   input  wire logic [2:0] fire,     // timer, pin, port
   output logic            tmr_ovf,  // overflow pulse
   output logic            pin,      // edge pin
   output logic            port_chg  // change level
);
   logic lvl = 1'h0;
   assign pin = lvl;
   always @(posedge hclk) begin
      tmr_ovf  <= fire[0];
      lvl      <= lvl ^ fire[1];
      port_chg <= fire[2];
   end
endmodule

// ---- pin_edge_detect.sv ----
`timescale 1ns/100ps
module pin_edge_detect (
   input  wire logic hclk,       // system clock
   input  wire logic hresetn,    // async reset, low
   input  wire logic pin,        // sampled pin level
   input  wire logic rising_sel, // 1 rising, 0 falling
   output logic      edge_pulse  // one-cycle pulse
);
   logic prev_q;
   logic armed_q;
   logic rise;
   logic fall;

   assign rise       = pin & ~prev_q;
   assign fall       = ~pin & prev_q;
   // no edge until a first sample is held
   assign edge_pulse = armed_q & (rising_sel ? rise : fall);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q  <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         prev_q  <= pin;
         armed_q <= 1'b1;
      end
   end
endmodule

// ---- sticky_flag_cell.sv ----
`timescale 1ns/100ps
module sticky_flag_cell (
   input  wire logic hclk,    // system clock
   input  wire logic hresetn, // async reset, low
   input  wire logic set,     // hardware event
   input  wire logic wr_en,   // software write
   input  wire logic wr_val,  // value written
   output logic      q        // flag state
);
   logic q_d;

   // event beats a simultaneous write
   assign q_d = set ? 1'b1 : (wr_en ? wr_val : q);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= 1'b0;
      end else begin
         q <= q_d;
      end
   end
endmodule

// ---- test_core_interrupt_control_reg.sv ----
`timescale 1ns/100ps
module test_core_interrupt_control_reg;
   import core_irq_pkg::*;
   logic        hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, pend = 1'h0, esel = 1'h1;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  fire = 3'h0, hsz = HSIZE_WORD;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rq;
   logic        hreadyout, hresp, tov, pin, pch, creq, irq;
   int          fails = 0, tests_run = 0;
   always #20 hclk = ~hclk;
   event_source_model src_u (.hclk(hclk), .fire(fire), .tmr_ovf(tov), .pin(pin),
      .port_chg(pch));
   core_interrupt_control_reg dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsz),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .timer0_overflow(tov), .portb_mismatch(pch),
      .external_edge_pin(pin), .edge_rising_sel(esel), .periph_irq_pend(pend),
      .core_irq_req(creq), .irq(irq));
   task automatic rdy;
      logic r;
      do begin
         @(negedge hclk);
         r  = hreadyout;
         rq = hrdata;
         @(posedge hclk);
      end while (r !== 1'h1);
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      haddr  <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      rdy;
      htrans <= 2'h0;
      hwdata <= d;
      rdy;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(n, e, rq);
   endtask
   task automatic req(input logic [1:0] e);
      @(negedge hclk);
      chk("req,irq", {30'h0, e}, {30'h0, creq, irq});
      @(posedge hclk);
   endtask
   task automatic ev(input logic [2:0] f);
      fire <= f;
      @(posedge hclk);
      fire <= 3'h0;
      repeat (3) @(posedge hclk);
   endtask
   task automatic t_reset;
      rd("control", ADDR_CTRL_BANK0, {24'h0, CTRL_RESET});
      rd("enable", ADDR_EVT_ENABLE, {29'h0, EVT_EN_RESET});
      req(2'h0);
      chk("resp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
   endtask
   task automatic t_banks;
      logic [11:0] b[4] = '{ADDR_CTRL_BANK0, ADDR_CTRL_BANK1, ADDR_CTRL_BANK2, ADDR_CTRL_BANK3};
      for (int i = 0; i < 4; i++) begin
         bus(1'h1, b[i], 32'h11 << i);
         rd("alias", b[(i + 1) % 4], 32'h11 << i);
      end
      rd("unmapped", 12'h030, 32'h0);
   endtask
   task automatic t_flags;
      bus(1'h1, ADDR_CTRL_BANK0, 32'h0);
      ev(3'h7);
      rd("flags", ADDR_CTRL_BANK1, 32'h7);
      req(2'h0);
      bus(1'h1, ADDR_CTRL_BANK2, 32'h0);
      bus(1'h1, ADDR_CTRL_BANK3, 32'hb8);
      req(2'h0);
      ev(3'h1);
      req(2'h2);
      rd("timer", ADDR_CTRL_BANK0, 32'hbc);
   endtask
   task automatic t_periph;
      pend <= 1'h1;
      bus(1'h1, ADDR_CTRL_BANK0, 32'h80);
      req(2'h0);
      bus(1'h1, ADDR_CTRL_BANK0, 32'hc0);
      req(2'h2);
      bus(1'h1, ADDR_CTRL_BANK0, 32'h40);
      req(2'h0);
      pend <= 1'h0;
   endtask
   task automatic t_irq;
      bus(1'h1, ADDR_EVT_CLEAR, 32'h7);
      ev(3'h1);
      rd("status", ADDR_EVT_STATUS, 32'h4);
      req(2'h0);
      bus(1'h1, ADDR_EVT_ENABLE, 32'h4);
      req(2'h1);
      bus(1'h1, ADDR_EVT_CLEAR, 32'h4);
      req(2'h0);
      rd("status", ADDR_EVT_STATUS, 32'h0);
   endtask
   task automatic t_edge;
      bus(1'h1, ADDR_CTRL_BANK0, 32'h0);
      esel <= 1'h0;
      ev(3'h2);
      rd("fall", ADDR_CTRL_BANK1, 32'h2);
      bus(1'h1, ADDR_CTRL_BANK0, 32'h0);
      ev(3'h2);
      rd("rise", ADDR_CTRL_BANK2, 32'h0);
      esel <= 1'h1;
      hsz  <= 3'h0;
      bus(1'h1, ADDR_CTRL_BANK0, 32'hff);
      hsz  <= HSIZE_WORD;
      rd("bytewr", ADDR_CTRL_BANK3, 32'h0);
      bus(1'h1, ADDR_CTRL_BANK0, 32'ha4);
      req(2'h2);
      bus(1'h1, ADDR_CTRL_BANK0, 32'h0);
      req(2'h0);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge hclk);
      fails++;
      close_out;
   end
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      t_reset;
      t_banks;
      t_flags;
      t_periph;
      t_irq;
      t_edge;
      close_out;
   end
endmodule
